// file: common/hrb_consts.vh
/*
 Constants of the hub reset, boot and port control block.
 Assumes inclusion by bare name from the design files; definitions only.
*/
// Function
// - Flash boot checks signature at 0xFFFA
// - Valid signature: run flash from 0x0000
// - No signature: stay on internal ROM
// - Mgmt slave needs strap and both pull-ups
// - OTP via USB runtime, mgmt in config
// - Four attach inputs gate PHY clocks
// - Per-port charger indication on port pins
// - Only port 1 swaps with upstream
// - Swap request low default, high swapped
// - Swap status mirrors actual arrangement
// - Mgmt registers control swap after enumeration
// - Hard reset: hi-Z, defaults, clocks halted
// - Power-on timer holds internal reset
// - Bus reset: address 0, unconfigured, resume
// - Upstream reset never forwarded downstream
// - Flash access from host is pass-through
// - Host may override charging settings
// - Config stage waits for write 0xFF
// - Reset low: standby, PLL stopped
`ifndef HRB_CONSTS_VH
`define HRB_CONSTS_VH
`define HRB_SIG_ADDR 16'hfffa
`define HRB_BOOT_ADDR 16'h0000
`define HRB_SIG_WORD 32'h32444655
`define HRB_CFG_END_REG 8'hff
`define HRB_USB_ADDR_RST 7'h00
`define HRB_POR_NS 1000
`define HRB_CLK_NS 100
`define HRB_POR_CYC ((`HRB_POR_NS + `HRB_CLK_NS - 1) / `HRB_CLK_NS)
`define HRB_PORTS_DN 7
`define HRB_ATTACH_N 4
`endif

// file: logic/hrb_sync.v
/*
 Two flip-flop synchroniser for a bus of levels.
 Assumes inputs may change at any time relative to ref_clk.
*/
`timescale 1ns/100ps
module hrb_sync #(
   parameter W = 1
) (
   // Clock and reset
   input wire ref_clk,
   input wire sys_rst,
   // Data
   input wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] s1_r;
   reg [W-1:0] s2_r;
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         s1_r <= {W{1'b0}};
         s2_r <= {W{1'b0}};
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
      end
   end
   assign q = s2_r;
endmodule

// file: logic/hrb_core.v
/*
 Boot sequencer, reset handling and port control of the hub.
 Assumes firmware-side engines: a flash reader returns the signature word,
 a management-bus slave decodes writes, and a USB engine signals bus reset.
*/
`timescale 1ns/100ps
`include "hrb_consts.vh"
module hrb_core #(
   parameter POR_CYC = `HRB_POR_CYC,
   parameter NDN = `HRB_PORTS_DN,
   parameter NATT = `HRB_ATTACH_N
) (
   // Clock and resets
   input wire ref_clk,
   input wire sys_rst,
   input wire reset_pin_n,
   // Straps sampled at boot
   input wire strap_flash_boot,
   input wire strap_mgmt_cfg,
   input wire mgmt_bus_data_pin,
   input wire mgmt_bus_clock_pin,
   // Flash signature read
   output wire sig_rd_req,
   output wire [15:0] sig_rd_addr,
   input wire sig_rd_valid,
   input wire [31:0] sig_rd_data,
   // Code fetch selection
   output reg code_from_flash_r,
   output reg [15:0] fetch_start_r,
   // Host flash pass-through
   input wire host_flash_req,
   input wire [7:0] host_flash_wdata,
   output wire flash_pt_req,
   output wire [7:0] flash_pt_wdata,
   // Management bus writes
   input wire mgmt_wr,
   input wire [7:0] mgmt_addr,
   input wire mgmt_wdata0,
   input wire mgmt_swap_wr,
   // OTP access requests
   input wire usb_otp_req,
   input wire mgmt_otp_req,
   output wire otp_grant_usb,
   output wire otp_grant_mgmt,
   // USB side
   input wire usb_bus_reset,
   input wire usb_enumerated,
   output reg [6:0] usb_addr_r,
   output reg usb_configured_r,
   output reg usb_suspended_r,
   input wire usb_suspend_req,
   output wire dn_reset_fwd,
   // Charging configuration
   input wire [NDN-1:0] chg_cfg,
   input wire host_chg_wr,
   input wire [NDN-1:0] host_chg_val,
   output wire [NDN-1:0] port_power_ctl,
   output wire [NDN-1:0] port_power_ctl_oe,
   // Type-C attach and PHY clocks
   input wire [NATT-1:0] attach_in,
   output wire [NATT-1:0] phy_clk_en,
   // Port swap
   input wire swap_request_in,
   output wire swap_status_out,
   output wire upstream_is_port1,
   // Status
   output wire phy_hiz,
   output wire pll_run,
   output wire osc_run,
   output wire mgmt_slave_en,
   output wire [5:0] stage
);
   localparam ST_POR = 6'h01;
   localparam ST_SIG = 6'h02;
   localparam ST_STRAP = 6'h04;
   localparam ST_SOC = 6'h08;
   localparam ST_RUN = 6'h10;
   localparam ST_STBY = 6'h20;

   reg [5:0] st_r;
   reg [5:0] st_nxt;
   reg [15:0] por_cnt_r;
   reg mgmt_en_r;
   reg [NDN-1:0] chg_ovr_r;
   reg chg_ovr_en_r;
   reg swap_reg_r;
   reg swap_reg_use_r;
   reg swap_r;
   wire [NATT-1:0] att_s;
   wire swap_pin_s;
   wire por_done;
   wire flash_ok;
   wire pullups;

   hrb_sync #(.W(NATT + 1)) u_sync (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .d({swap_request_in, attach_in}),
      .q({swap_pin_s, att_s})
   );

   assign por_done = (por_cnt_r == POR_CYC[15:0]);
   assign flash_ok = sig_rd_valid && (sig_rd_data == `HRB_SIG_WORD);
   assign pullups = mgmt_bus_data_pin && mgmt_bus_clock_pin;

   // Power-on timer; hard reset pin restarts it
   always @(posedge ref_clk) begin
      if (sys_rst || !reset_pin_n)
         por_cnt_r <= 16'h0000;
      else if (!por_done)
         por_cnt_r <= por_cnt_r + 16'h0001;
   end

   // Boot stage sequencing
   always @* begin
      st_nxt = st_r;
      case (st_r)
         ST_POR: begin
            if (por_done)
               st_nxt = strap_flash_boot ? ST_SIG : ST_STRAP;
         end
         ST_SIG: begin
            if (sig_rd_valid)
               st_nxt = ST_STRAP;
         end
         ST_STRAP: begin
            if (strap_mgmt_cfg && pullups)
               st_nxt = ST_SOC;
            else
               st_nxt = ST_RUN;
         end
         ST_SOC: begin
            if (mgmt_wr && mgmt_addr == `HRB_CFG_END_REG)
               st_nxt = ST_RUN;
         end
         ST_RUN: st_nxt = ST_RUN;
         ST_STBY: st_nxt = ST_POR;
         default: st_nxt = ST_POR;
      endcase
   end

   always @(posedge ref_clk) begin
      if (sys_rst)
         st_r <= ST_POR;
      else if (!reset_pin_n)
         st_r <= ST_STBY;
      else
         st_r <= st_nxt;
   end

   // Code store and management slave enable
   always @(posedge ref_clk) begin
      if (sys_rst || !reset_pin_n) begin
         code_from_flash_r <= 1'b0;
         fetch_start_r <= `HRB_BOOT_ADDR;
         mgmt_en_r <= 1'b0;
      end else begin
         if (st_r == ST_SIG && flash_ok) begin
            code_from_flash_r <= 1'b1;
            fetch_start_r <= `HRB_BOOT_ADDR;
         end
         if (st_r == ST_STRAP)
            mgmt_en_r <= strap_mgmt_cfg && pullups;
      end
   end

   assign sig_rd_req = (st_r == ST_SIG);
   assign sig_rd_addr = `HRB_SIG_ADDR;
   assign mgmt_slave_en = mgmt_en_r;
   assign stage = st_r;

   // Flash pass-through from host, contents not interpreted
   assign flash_pt_req = host_flash_req && (st_r == ST_RUN);
   assign flash_pt_wdata = host_flash_wdata;

   // OTP access paths depend on stage
   assign otp_grant_usb = usb_otp_req && (st_r == ST_RUN);
   assign otp_grant_mgmt = mgmt_otp_req && (st_r == ST_SOC);

   // USB device state; bus reset wins over suspend and enumeration, hard reset wins over bus reset
   always @(posedge ref_clk) begin
      if (sys_rst || !reset_pin_n) begin
         usb_addr_r <= `HRB_USB_ADDR_RST;
         usb_configured_r <= 1'b0;
         usb_suspended_r <= 1'b0;
      end else if (usb_bus_reset) begin
         usb_addr_r <= `HRB_USB_ADDR_RST;
         usb_configured_r <= 1'b0;
         usb_suspended_r <= 1'b0;
      end else begin
         if (usb_suspend_req)
            usb_suspended_r <= 1'b1;
         if (usb_enumerated)
            usb_configured_r <= 1'b1;
      end
   end
   assign dn_reset_fwd = 1'b0;

   // Charging indication with host override
   always @(posedge ref_clk) begin
      if (sys_rst || !reset_pin_n) begin
         chg_ovr_r <= {NDN{1'b0}};
         chg_ovr_en_r <= 1'b0;
      end else if (host_chg_wr && st_r == ST_RUN) begin
         chg_ovr_r <= host_chg_val;
         chg_ovr_en_r <= 1'b1;
      end
   end
   // Pin drives low for "no charger", released (pulled high) for present
   assign port_power_ctl = {NDN{1'b0}};
   assign port_power_ctl_oe = (st_r == ST_RUN) ?
      ~(chg_ovr_en_r ? chg_ovr_r : chg_cfg) : {NDN{1'b0}};

   // Type-C attach gates PHY clocking
   assign phy_clk_en = (st_r == ST_RUN) ? att_s : {NATT{1'b0}};

   // Port swap: pin by default, register after enumeration
   always @(posedge ref_clk) begin
      if (sys_rst || !reset_pin_n) begin
         swap_reg_r <= 1'b0;
         swap_reg_use_r <= 1'b0;
         swap_r <= 1'b0;
      end else begin
         if (mgmt_swap_wr && mgmt_en_r && usb_configured_r) begin
            swap_reg_r <= mgmt_wdata0;
            swap_reg_use_r <= 1'b1;
         end
         swap_r <= swap_reg_use_r ? swap_reg_r : swap_pin_s;
      end
   end
   assign upstream_is_port1 = swap_r;
   assign swap_status_out = swap_r;

   // Standby while the hard reset pin is low
   assign phy_hiz = !reset_pin_n || st_r == ST_STBY;
   assign pll_run = reset_pin_n && st_r != ST_STBY;
   assign osc_run = reset_pin_n && st_r != ST_STBY;
endmodule

// file: testbench/hrb_chk.sv
/* Port checker of the hub boot, reset and port control core.
 Assumes binding to hrb_core; one clock, synchronous reset. */
`timescale 1ns/100ps
module hrb_chk (
   // Clock and pins
   input logic ref_clk, sys_rst, reset_pin_n,
   input logic strap_mgmt_cfg, mgmt_bus_data_pin, mgmt_bus_clock_pin,
   // Signature read and fetch
   input logic sig_rd_req, sig_rd_valid, code_from_flash_r,
   input logic [15:0] sig_rd_addr, fetch_start_r,
   input logic [31:0] sig_rd_data,
   // Management and USB
   input logic mgmt_wr, otp_grant_usb, otp_grant_mgmt, usb_bus_reset,
   input logic [7:0] mgmt_addr,
   input logic [6:0] usb_addr_r,
   input logic usb_configured_r, usb_suspended_r, dn_reset_fwd,
   // Ports and status
   input logic [3:0] attach_in, phy_clk_en,
   input logic swap_request_in, swap_status_out, upstream_is_port1,
   input logic phy_hiz, pll_run, osc_run,
   input logic [5:0] stage
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   sequence good_sig_s;
      reset_pin_n && stage == 6'h02 && sig_rd_valid;
   endsequence
   sequence cfg_end_s;
      reset_pin_n && stage == 6'h08 && mgmt_wr && mgmt_addr == 8'hff;
   endsequence
   no_fwd_a: assert property (dn_reset_fwd == 1'b0) else $error("fwd");
   hiz_a: assert property (!reset_pin_n |-> phy_hiz && !pll_run && !osc_run)
      else $error("standby outputs");
   stby_a: assert property (!reset_pin_n |=> stage == 6'h20)
      else $error("no standby");
   sig_addr_a: assert property (sig_rd_req |-> stage == 6'h02
      && sig_rd_addr == 16'hfffa) else $error("sig addr");
   flash_run_a: assert property (good_sig_s ##0 sig_rd_data == 32'h32444655
      |=> code_from_flash_r && fetch_start_r == 16'h0000)
      else $error("flash boot");
   rom_run_a: assert property (good_sig_s ##0 sig_rd_data != 32'h32444655
      |=> !code_from_flash_r) else $error("rom boot");
   slave_det_a: assert property (reset_pin_n && stage == 6'h04 |=>
      stage == ($past(strap_mgmt_cfg && mgmt_bus_data_pin
      && mgmt_bus_clock_pin) ? 6'h08 : 6'h10)) else $error("slave");
   otp_path_a: assert property ((otp_grant_mgmt |-> stage == 6'h08) and
      (otp_grant_usb |-> stage == 6'h10)) else $error("otp path");
   cfg_end_a: assert property (cfg_end_s |=> stage == 6'h10)
      else $error("cfg end");
   bus_rst_a: assert property (reset_pin_n && usb_bus_reset |=> usb_addr_r
      == 7'h00 && !usb_configured_r && !usb_suspended_r)
      else $error("bus reset");
   attach_a: assert property (stage == 6'h10 && $past(stage, 2) == 6'h10
      |-> phy_clk_en == $past(attach_in, 2)) else $error("attach");
   swap_mir_a: assert property (swap_status_out == upstream_is_port1)
      else $error("swap mirror");
   swap_hi_a: assert property ((stage == 6'h10 && swap_request_in)[*4]
      |-> swap_status_out) else $error("swap high");
   swap_lo_a: assert property ((stage == 6'h10 && !swap_request_in)[*4]
      |-> !swap_status_out) else $error("swap low");
endmodule

// file: testbench/hrb_flash_model.sv
/* Serial flash holding the boot signature, answering lat+1 cycles after the request.
 Assumes a bench that picks latency and whether the word is valid. */
`timescale 1ns/100ps
module hrb_flash_model (
   // Request side
   input logic ref_clk, sig_rd_req, good,
   input logic [3:0] lat,
   // Reply
   output logic sig_rd_valid = 1'b0,
   output logic [31:0] sig_rd_data = 32'h5a5a5a5a
);
   logic [3:0] cnt_r = 4'h0;
   always @(posedge ref_clk) begin
      sig_rd_valid <= 1'b0;
      // Data toggles every cycle between replies
      sig_rd_data <= ~sig_rd_data;
      cnt_r <= sig_rd_req ? cnt_r + 4'h1 : 4'h0;
      if (sig_rd_req && cnt_r == lat) begin
         sig_rd_valid <= 1'b1;
         sig_rd_data <= good ? 32'h32444655 : 32'h32444654;
      end
   end
endmodule

// file: testbench/hub_reset_boot_port_control_bench.sv
/* Self-checking bench of hrb_core with a flash model and bound checker.
 Assumes POR_CYC reduced to 3 and the swap register path left unused. */
`timescale 1ns/100ps
module hub_reset_boot_port_control_bench;
   logic ref_clk = 0, sys_rst = 1, reset_pin_n = 1, strap_flash_boot = 0;
   logic strap_mgmt_cfg = 0, mgmt_bus_data_pin = 0, mgmt_bus_clock_pin = 0;
   logic host_flash_req = 0, mgmt_wr = 0, mgmt_wdata0 = 0, mgmt_swap_wr = 0;
   logic usb_otp_req = 0, mgmt_otp_req = 0, usb_bus_reset = 0, good = 0;
   logic usb_enumerated = 0, usb_suspend_req = 0, host_chg_wr = 0;
   logic swap_request_in = 0, ovr = 0, wr_bit = 0;
   logic [3:0] a1 = 0, a2 = 0;
   logic [2:0] sh = 0;
   logic [7:0] host_flash_wdata = 0, mgmt_addr = 0, flash_pt_wdata;
   logic [6:0] chg_cfg = 0, host_chg_val = 0, ov_val = 0, usb_addr_r;
   logic [6:0] port_power_ctl, port_power_ctl_oe;
   logic [3:0] attach_in = 0, phy_clk_en, lat = 0;
   logic [31:0] sig_rd_data, r = 32'h262d;
   logic [15:0] sig_rd_addr, fetch_start_r;
   logic [5:0] stage;
   logic sig_rd_req, sig_rd_valid, code_from_flash_r, flash_pt_req;
   logic otp_grant_usb, otp_grant_mgmt, usb_configured_r, usb_suspended_r;
   logic dn_reset_fwd, swap_status_out, upstream_is_port1, phy_hiz;
   logic pll_run, osc_run, mgmt_slave_en;
   integer fail_count = 0, n_tests = 0, cyc = 0, k, i;
   hrb_core #(.POR_CYC(3)) dut_u (.*);
   hrb_flash_model flash_u (.*);
   always #50 ref_clk = ~ref_clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic tick;
      @(posedge ref_clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_tests++;
      if (e !== g) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic results;
      if (fail_count == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         results;
      end
   end
   initial begin
      repeat (10) tick;
      sys_rst = 0;
      for (k = 0; k < 8; k++) begin
         r = lfsr(r);
         lat = r[3:0];
         good = k[0];
         strap_flash_boot = k[2];
         {strap_mgmt_cfg, mgmt_bus_data_pin, mgmt_bus_clock_pin} = {3{k[1]}};
         reset_pin_n = 0;
         tick;
         chk("phy_hiz", 1, phy_hiz);
         chk("stage", 6'h20, stage);
         chk("pll_osc_run", 0, {pll_run, osc_run});
         reset_pin_n = 1;
         for (i = 0; i < 60 && !(stage[3] | stage[4]); i++) tick;
         if (!k[2])
            chk("por_cycles", 3 + 2, i);
         chk("mgmt_slave_en", k[1], mgmt_slave_en);
         chk("code_from_flash_r", k[2] & k[0], code_from_flash_r);
         chk("stage", k[1] ? 6'h08 : 6'h10, stage);
         mgmt_addr = 8'hff;
         mgmt_wr = k[1];
         tick;
         mgmt_wr = 0;
         chk("stage", 6'h10, stage);
      end
      repeat (300) begin
         if (host_chg_wr) {ovr, ov_val} = {1'b1, host_chg_val};
         if (usb_bus_reset)
            chk("usb_state", 0, {usb_configured_r, usb_suspended_r,
               usb_addr_r});
         {a2, a1, sh} = {a1, attach_in, sh[1:0], swap_request_in};
         r = lfsr(r);
         {attach_in, usb_bus_reset, usb_suspend_req, host_flash_req,
            host_flash_wdata, wr_bit, host_chg_val, usb_otp_req,
            mgmt_otp_req, usb_enumerated, chg_cfg} = {r, r[4]};
         if (r[31:29] == 0) swap_request_in = ~swap_request_in;
         host_chg_wr = wr_bit & r[9];
         #1;
         chk("phy_clk_en", a2, phy_clk_en);
         chk("swap_status_out", sh[2], swap_status_out);
         chk("upstream_is_port1", sh[2], upstream_is_port1);
         chk("otp_grant_usb", usb_otp_req, otp_grant_usb);
         chk("otp_grant_mgmt", 0, otp_grant_mgmt);
         chk("dn_reset_fwd", 0, dn_reset_fwd);
         chk("port_power_ctl", 0, port_power_ctl);
         chk("port_power_ctl_oe", 7'(~(ovr ? ov_val : chg_cfg)),
            port_power_ctl_oe);
         chk("flash_pt_req", host_flash_req, flash_pt_req);
         if (host_flash_req)
            chk("flash_pt_wdata", host_flash_wdata, flash_pt_wdata);
         tick;
      end
      results;
   end
endmodule
bind hrb_core hrb_chk chk_u (.*);
